// ### core/cpu_state_cfg.svh
// Constants for the core register file and mode state
`ifndef CPU_STATE_CFG_SVH
`define CPU_STATE_CFG_SVH
`define REG_NUM_SP        4'hD
`define REG_NUM_LR        4'hE
`define REG_NUM_PC        4'hF
`define REG_LOW_LAST      4'h7
`define REG_HIGH_LAST     4'hC
`define SPEC_PSW          4'h0
`define SPEC_APP          4'h1
`define SPEC_INT          4'h2
`define SPEC_EXE          4'h3
`define SPEC_PRIORITY_MASK_BIT      4'h4
`define SPEC_FAULT_MASK_BIT    4'h5
`define SPEC_BASE_PRIORITY_THRESHOLD      4'h6
`define SPEC_CONTROL      4'h7
`define SPEC_MSP          4'h8
`define SPEC_PSP          4'h9
`define APP_MASK          32'hF800_0000
`define INT_MASK          32'h0000_01FF
`define EXE_MASK          32'h0600_FC00
`define EXE_TBIT          24
`define PSW_RESET         32'h0100_0000
`define SP_ALIGN_MASK     32'hFFFF_FFFC
`define PC_ALIGN_MASK     32'hFFFF_FFFE
`define EXC_NMI           9'h002
`define EXC_HARDFAULT     9'h003
`define EXC_FIRST_IRQ     9'h010
`define CTRL_USER_BIT     0
`define CTRL_SPSEL_BIT    1
`endif

// ### core/cpu_state_pkg.sv
// Types shared by the core mode and register logic
package cpu_state_pkg;
	typedef enum logic [1:0] {
		ST_PRIV_THREAD = 2'b00,
		ST_USER_THREAD = 2'b01,
		ST_PRIV_HANDLER = 2'b10
	} run_state_e;
	typedef logic [31:0] word_t;
endpackage

// ### core/word_reg.sv
// One 32-bit register with write enable and alignment mask
`timescale 1ns/1ps
`include "cpu_state_cfg.svh"
module word_reg
#(
	parameter logic [31:0] KEEP_MASK = 32'hFFFF_FFFF
)
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	output logic      [31:0] q
);
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= 32'h0000_0000;
		else if (wr_en)
			q <= wr_data & KEEP_MASK;
	end
endmodule // word_reg

// ### core/exc_mask.sv
// Exception acceptance under the three mask registers
`timescale 1ns/1ps
`include "cpu_state_cfg.svh"
module exc_mask
(
	input  wire logic [8:0] exc_num,
	input  wire logic [8:0] exc_prio,
	input  wire logic       priority_mask_bit,
	input  wire logic       fault_mask_bit,
	input  wire logic [8:0] base_priority_threshold,
	output logic            accept
);
	wire logic is_nmi;
	wire logic is_hf;
	wire logic is_irq;
	wire logic base_block;
	assign is_nmi = (exc_num == `EXC_NMI);
	assign is_hf = (exc_num == `EXC_HARDFAULT);
	assign is_irq = (exc_num >= `EXC_FIRST_IRQ);
	// base blocks equal or higher value
	assign base_block = (base_priority_threshold != 9'h000) && is_irq &&
		(exc_prio >= base_priority_threshold);
	assign accept = is_nmi ||
		(!fault_mask_bit && is_hf) ||
		(!fault_mask_bit && !priority_mask_bit && !base_block);
endmodule // exc_mask

// ### core/cpu_mode_and_special_regs.sv
// Core register file, mode state and special registers
`timescale 1ns/1ps
`include "cpu_state_cfg.svh"
module cpu_mode_and_special_regs
	import cpu_state_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [3:0]  rd_num,
	input  wire logic        rd_narrow,
	output logic      [31:0] rd_data,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_num,
	input  wire logic        wr_narrow,
	input  wire logic [31:0] wr_data,
	input  wire logic        call_en,
	input  wire logic [31:0] call_ret_addr,
	input  wire logic        pc_load,
	input  wire logic [31:0] pc_next,
	input  wire logic        flags_en,
	input  wire logic [4:0]  flags_in,
	input  wire logic        spec_rd,
	input  wire logic        spec_wr,
	input  wire logic [3:0]  spec_sel,
	input  wire logic [31:0] spec_wdata,
	output logic      [31:0] spec_rdata,
	input  wire logic        restricted_op,
	input  wire logic        exc_enter,
	input  wire logic [8:0]  exc_enter_num,
	input  wire logic        exc_return,
	input  wire logic        exc_return_nest,
	input  wire logic [8:0]  exc_return_num,
	input  wire logic [8:0]  exc_req_num,
	input  wire logic [8:0]  exc_req_prio,
	output logic             exc_accept,
	output logic             priv_fault,
	output logic             tbit_fault,
	output logic             narrow_fault,
	output logic             in_handler,
	output logic             is_privileged,
	output logic             using_psp,
	output logic      [31:0] pc_out
);
	run_state_e  state_r;
	run_state_e  state_nxt;
	logic [31:0] gpr_q [0:12];
	logic [12:0] gpr_we;
	logic [31:0] msp_q;
	logic [31:0] psp_q;
	logic [31:0] lr_q;
	logic [31:0] pc_q;
	logic [31:0] psw_r;
	logic        priority_mask_bit_r;
	logic        fault_mask_bit_r;
	logic [8:0]  base_priority_threshold_r;
	logic [1:0]  ctrl_r;
	logic [31:0] rd_data_r;
	logic [31:0] spec_rdata_r;
	logic        priv_fault_r;
	logic        tbit_fault_r;
	logic        narrow_fault_r;
	logic        accept_r;
	logic        privileged;
	logic        handler;
	logic        sel_psp;
	logic        gpr_wr;
	logic        wr_high_bad;
	logic        rd_high_bad;
	logic        spec_ok;
	logic        spec_wr_ok;
	logic        psw_wr;
	logic [31:0] psw_wmask;
	logic        tbit_clear;
	logic        msp_we;
	logic        psp_we;
	logic        msp_spec;
	logic        psp_spec;
	logic        lr_we;
	logic        pc_we;
	logic [31:0] lr_wval;
	logic [31:0] pc_wval;
	logic [31:0] sp_now;
	logic [31:0] psw_view;
	logic [31:0] core_word;
	logic [31:0] spec_word;
	logic        accept_c;
	logic [1:0]  ctrl_wval;
	logic [31:0] psw_nxt;

	assign handler = (state_r == ST_PRIV_HANDLER);
	assign privileged = (state_r != ST_USER_THREAD);
	// process copy only in user thread or spsel
	assign sel_psp = !handler && (ctrl_r[`CTRL_SPSEL_BIT] ||
		(state_r == ST_USER_THREAD));

	// exception entry and return steer mode
	always_comb
	begin
		state_nxt = state_r;
		if (exc_enter)
			state_nxt = ST_PRIV_HANDLER;
		else if (exc_return && !exc_return_nest)
			state_nxt = ctrl_r[`CTRL_USER_BIT] ? ST_USER_THREAD
				: ST_PRIV_THREAD;
		else if (!handler)
			// control bit 0 picks thread level
			state_nxt = ctrl_r[`CTRL_USER_BIT] ? ST_USER_THREAD
				: ST_PRIV_THREAD;
	end

	// high registers refused to narrow forms
	assign wr_high_bad = wr_narrow && (wr_num > `REG_LOW_LAST) &&
		(wr_num <= `REG_HIGH_LAST);
	assign rd_high_bad = rd_narrow && (rd_num > `REG_LOW_LAST) &&
		(rd_num <= `REG_HIGH_LAST);
	assign gpr_wr = wr_en && !wr_high_bad && (wr_num <= `REG_HIGH_LAST);

	// thirteen general registers plus banked, link, counter
	genvar gi;
	generate
		for (gi = 0; gi <= 12; gi++)
		begin : g_gpr
			assign gpr_we[gi] = gpr_wr && (wr_num == 4'(gi));
			word_reg u_gpr
			(
				.core_clk (core_clk),
				.rst_b    (rst_b),
				.wr_en    (gpr_we[gi]),
				.wr_data  (wr_data),
				.q        (gpr_q[gi])
			);
		end
	endgenerate

	assign spec_ok = privileged || (spec_sel <= `SPEC_EXE);
	assign spec_wr_ok = spec_wr && (privileged ||
		spec_sel == `SPEC_APP || spec_sel == `SPEC_PSW);
	assign msp_spec = spec_wr_ok && (spec_sel == `SPEC_MSP);
	assign psp_spec = spec_wr_ok && (spec_sel == `SPEC_PSP);
	assign msp_we = (wr_en && wr_num == `REG_NUM_SP && !sel_psp) ||
		msp_spec;
	assign psp_we = (wr_en && wr_num == `REG_NUM_SP && sel_psp) ||
		psp_spec;
	// low two stack bits forced to zero
	word_reg #(.KEEP_MASK(`SP_ALIGN_MASK)) u_msp
	(
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.wr_en    (msp_we),
		.wr_data  (msp_spec ? spec_wdata : wr_data),
		.q        (msp_q)
	);
	word_reg #(.KEEP_MASK(`SP_ALIGN_MASK)) u_psp
	(
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.wr_en    (psp_we),
		.wr_data  (psp_spec ? spec_wdata : wr_data),
		.q        (psp_q)
	);
	// call loads return address into link
	assign lr_we = call_en || (wr_en && wr_num == `REG_NUM_LR);
	assign lr_wval = call_en ? call_ret_addr : wr_data;
	word_reg u_lr
	(
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.wr_en    (lr_we),
		.wr_data  (lr_wval),
		.q        (lr_q)
	);
	// counter bit zero forced to zero
	assign pc_we = pc_load || (wr_en && wr_num == `REG_NUM_PC);
	assign pc_wval = pc_load ? pc_next : wr_data;
	word_reg #(.KEEP_MASK(`PC_ALIGN_MASK)) u_pc
	(
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.wr_en    (pc_we),
		.wr_data  (pc_wval),
		.q        (pc_q)
	);

	// joint or separate status part masks
	assign psw_wmask = (spec_sel == `SPEC_PSW) ?
		(`APP_MASK | `EXE_MASK) :
		(spec_sel == `SPEC_APP) ? `APP_MASK :
		(spec_sel == `SPEC_EXE) ? `EXE_MASK : 32'h0000_0000;
	assign psw_wr = spec_wr_ok && |psw_wmask && !tbit_clear;
	// clearing compressed bit refused and faulted
	assign tbit_clear = spec_wr_ok && !spec_wdata[`EXE_TBIT] &&
		(spec_sel == `SPEC_PSW || spec_sel == `SPEC_EXE);
	always_comb
	begin
		psw_nxt = psw_r;
		if (psw_wr)
			psw_nxt = (psw_r & ~psw_wmask) | (spec_wdata & psw_wmask);
		if (flags_en)
			psw_nxt[31:27] = flags_in;
		if (exc_enter)
			psw_nxt[8:0] = exc_enter_num;
		else if (exc_return)
			psw_nxt[8:0] = exc_return_nest ? exc_return_num : 9'h000;
		psw_nxt[`EXE_TBIT] = 1'b1;
	end
	assign psw_view = psw_r & (`APP_MASK | `INT_MASK | `EXE_MASK);

	// stack select forced zero in handler
	assign ctrl_wval = {spec_wdata[`CTRL_SPSEL_BIT] &&
		!(handler || exc_enter), spec_wdata[`CTRL_USER_BIT]};

	assign sp_now = sel_psp ? psp_q : msp_q;
	assign core_word = (rd_num <= `REG_HIGH_LAST) ?
		(rd_high_bad ? 32'h0000_0000 : gpr_q[rd_num]) :
		(rd_num == `REG_NUM_SP) ? sp_now :
		(rd_num == `REG_NUM_LR) ? lr_q : pc_q;
	assign spec_word = !spec_ok ? 32'h0000_0000 :
		(spec_sel == `SPEC_PSW) ? {psw_view[31:25], 1'b1,
			psw_view[23:0]} :
		(spec_sel == `SPEC_APP) ? (psw_view & `APP_MASK) :
		(spec_sel == `SPEC_INT) ? (psw_view & `INT_MASK) :
		(spec_sel == `SPEC_EXE) ? ((psw_view & `EXE_MASK) |
			{7'h00, 1'b1, 24'h00_0000}) :
		(spec_sel == `SPEC_PRIORITY_MASK_BIT) ? {31'h0, priority_mask_bit_r} :
		(spec_sel == `SPEC_FAULT_MASK_BIT) ? {31'h0, fault_mask_bit_r} :
		(spec_sel == `SPEC_BASE_PRIORITY_THRESHOLD) ? {23'h0, base_priority_threshold_r} :
		(spec_sel == `SPEC_CONTROL) ? {30'h0, ctrl_r} :
		(spec_sel == `SPEC_MSP) ? msp_q :
		(spec_sel == `SPEC_PSP) ? psp_q : 32'h0000_0000;

	exc_mask u_mask
	(
		.exc_num   (exc_req_num),
		.exc_prio  (exc_req_prio),
		.priority_mask_bit   (priority_mask_bit_r),
		.fault_mask_bit (fault_mask_bit_r),
		.base_priority_threshold   (base_priority_threshold_r),
		.accept    (accept_c)
	);

	// reset to privileged thread, masks clear
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= ST_PRIV_THREAD;
			psw_r <= `PSW_RESET;
			priority_mask_bit_r <= 1'b0;
			fault_mask_bit_r <= 1'b0;
			base_priority_threshold_r <= 9'h000;
			ctrl_r <= 2'b00;
		end
		else
		begin
			state_r <= state_nxt;
			psw_r <= psw_nxt;
			if (spec_wr_ok && spec_sel == `SPEC_PRIORITY_MASK_BIT)
				priority_mask_bit_r <= spec_wdata[0];
			if (spec_wr_ok && spec_sel == `SPEC_FAULT_MASK_BIT)
				fault_mask_bit_r <= spec_wdata[0];
			else if (exc_return && !exc_return_nest)
				fault_mask_bit_r <= 1'b0;
			if (spec_wr_ok && spec_sel == `SPEC_BASE_PRIORITY_THRESHOLD)
				base_priority_threshold_r <= spec_wdata[8:0];
			if (spec_wr_ok && spec_sel == `SPEC_CONTROL)
				ctrl_r <= ctrl_wval;
			else if (exc_enter)
				ctrl_r[`CTRL_SPSEL_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data_r <= 32'h0000_0000;
			spec_rdata_r <= 32'h0000_0000;
			priv_fault_r <= 1'b0;
			tbit_fault_r <= 1'b0;
			narrow_fault_r <= 1'b0;
			accept_r <= 1'b0;
		end
		else
		begin
			rd_data_r <= core_word;
			spec_rdata_r <= spec_rd ? spec_word : 32'h0000_0000;
			// user access to restricted items faults
			priv_fault_r <= !privileged && (restricted_op ||
				(spec_rd && !spec_ok) ||
				(spec_wr && !spec_wr_ok));
			tbit_fault_r <= tbit_clear;
			narrow_fault_r <= (wr_en && wr_high_bad) || rd_high_bad;
			accept_r <= accept_c;
		end
	end

	assign rd_data = rd_data_r;
	assign spec_rdata = spec_rdata_r;
	assign priv_fault = priv_fault_r;
	assign tbit_fault = tbit_fault_r;
	assign narrow_fault = narrow_fault_r;
	assign exc_accept = accept_r;
	assign in_handler = handler;
	assign is_privileged = privileged;
	assign using_psp = sel_psp;
	assign pc_out = pc_q;

	a_state_legal: assert property (@(posedge core_clk) disable iff
		(!rst_b) state_r != 2'b11) else $error("bad state");
	a_enter_handler: assert property (@(posedge core_clk) disable iff
		(!rst_b) exc_enter |=> in_handler && is_privileged)
		else $error("no handler");
	a_user_fault: assert property (@(posedge core_clk) disable iff
		(!rst_b) !privileged && restricted_op |=> priv_fault)
		else $error("no fault");
	a_priv_nofault: assert property (@(posedge core_clk) disable iff
		(!rst_b) privileged && !spec_wr |=> !priv_fault)
		else $error("spurious fault");
	a_sp_align: assert property (@(posedge core_clk) disable iff
		(!rst_b) msp_q[1:0] == 2'b00 && psp_q[1:0] == 2'b00)
		else $error("sp misaligned");
	a_pc_align: assert property (@(posedge core_clk) disable iff
		(!rst_b) pc_out[0] == 1'b0) else $error("pc odd");
	a_call_link: assert property (@(posedge core_clk) disable iff
		(!rst_b) call_en |=> lr_q == $past(call_ret_addr))
		else $error("link lost");
	a_tbit_one: assert property (@(posedge core_clk) disable iff
		(!rst_b) psw_r[24]) else $error("tbit clear");
	a_fault_mask: assert property (@(posedge core_clk) disable iff
		(!rst_b) fault_mask_bit_r && exc_req_num != `EXC_NMI |=> !exc_accept)
		else $error("fault_mask_bit leak");
	a_handler_spsel: assert property (@(posedge core_clk) disable iff
		(!rst_b) in_handler |-> !using_psp)
		else $error("psp in handler");
	c_enter: cover property (@(posedge core_clk) exc_enter);
	c_user: cover property (@(posedge core_clk)
		state_r == ST_USER_THREAD);
	c_fault: cover property (@(posedge core_clk) priv_fault);
endmodule // cpu_mode_and_special_regs

// ### verif/exc_source.sv
// Exception entry and return sequencer facing the core state logic
`timescale 1ns/1ps
module exc_source
(
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       req,
	input  wire logic       req_ret,
	input  wire logic       req_nest,
	input  wire logic [8:0] req_num,
	input  wire logic [3:0] lat,
	output logic            exc_enter,
	output logic            exc_return,
	output logic            exc_return_nest,
	output logic      [8:0] exc_enter_num,
	output logic      [8:0] exc_return_num
);
	logic [3:0] cnt_r;
	logic       pend_r;
	logic       ret_r;
	logic       nest_r;
	logic [8:0] num_r;
	wire        fire = pend_r && (cnt_r == 4'h0);
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{cnt_r, pend_r, ret_r, nest_r, num_r} <= '0;
			{exc_enter, exc_return, exc_return_nest} <= 3'h0;
			{exc_enter_num, exc_return_num} <= '0;
		end
		else
		begin
			if (req)
			begin
				{pend_r, ret_r, nest_r} <= {1'b1, req_ret, req_nest};
				{cnt_r, num_r} <= {lat, req_num};
			end
			else if (pend_r && !fire)
				cnt_r <= cnt_r - 4'h1;
			else if (fire)
				pend_r <= 1'b0;
			// one entry or return per request
			exc_enter <= fire && !ret_r;
			exc_return <= fire && ret_r;
			// number qualified only by its pulse
			exc_enter_num <= fire ? num_r : ~exc_enter_num;
			exc_return_num <= fire ? num_r : ~exc_return_num;
			exc_return_nest <= fire ? nest_r : ~exc_return_nest;
		end
	end
endmodule // exc_source

// ### verif/cpu_mode_and_special_regs_tb.sv
// Self-checking bench for the core mode and special register logic
`timescale 1ns/1ps
`include "cpu_state_cfg.svh"
module cpu_mode_and_special_regs_tb
	import cpu_state_pkg::*;
;
	logic        core_clk, rst_b, rd_narrow, wr_en, wr_narrow, call_en;
	logic        pc_load, flags_en, spec_rd, spec_wr, restricted_op;
	logic        exc_enter, exc_return, exc_return_nest, exc_accept;
	logic        priv_fault, tbit_fault, narrow_fault, in_handler;
	logic        is_privileged, using_psp, x_req, x_ret, x_nest;
	logic [3:0]  rd_num, wr_num, spec_sel, x_lat;
	logic [4:0]  flags_in;
	logic [8:0]  exc_enter_num, exc_return_num, exc_req_num;
	logic [8:0]  exc_req_prio, x_num;
	word_t       wr_data, call_ret_addr, pc_next, spec_wdata, rd_data;
	word_t       spec_rdata, pc_out, lfsr_r, v, w, e;
	word_t       gpr[13];
	int          n_fail, n_compared;
	cpu_mode_and_special_regs i_cpu_mode_and_special_regs (.core_clk,
		.rst_b, .rd_num, .rd_narrow, .rd_data, .wr_en, .wr_num, .wr_narrow,
		.wr_data, .call_en, .call_ret_addr, .pc_load, .pc_next, .flags_en,
		.flags_in, .spec_rd, .spec_wr, .spec_sel, .spec_wdata, .spec_rdata,
		.restricted_op, .exc_enter, .exc_enter_num, .exc_return,
		.exc_return_nest, .exc_return_num, .exc_req_num, .exc_req_prio,
		.exc_accept, .priv_fault, .tbit_fault, .narrow_fault, .in_handler,
		.is_privileged, .using_psp, .pc_out);
	exc_source i_exc_source (.core_clk, .rst_b, .req(x_req),
		.req_ret(x_ret), .req_nest(x_nest), .req_num(x_num), .lat(x_lat),
		.exc_enter, .exc_return, .exc_return_nest, .exc_enter_num,
		.exc_return_num);
	function automatic word_t rnd();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31]^lfsr_r[21]^lfsr_r[1]^lfsr_r[0]};
		return lfsr_r;
	endfunction
	function automatic word_t exe_exp(input word_t d);
		return (d & `EXE_MASK) | 32'h0100_0000;
	endfunction
	task automatic cmp_word(input word_t got, exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %0t %s got %b", $time, m, got);
		end
	endtask
	task automatic core_wr(input logic [3:0] n, input logic nr, word_t d);
		@(posedge core_clk);
		{wr_en, wr_num, wr_narrow, wr_data} <= {1'b1, n, nr, d};
		@(posedge core_clk);
		wr_en <= 1'b0;
		#1;
	endtask
	task automatic core_rd(input logic [3:0] n, input logic nr);
		@(posedge core_clk);
		{rd_num, rd_narrow} <= {n, nr};
		@(posedge core_clk);
		#1 v = rd_data;
	endtask
	task automatic sp_wr(input logic [3:0] s, input word_t d);
		@(posedge core_clk);
		{spec_wr, spec_sel, spec_wdata} <= {1'b1, s, d};
		@(posedge core_clk);
		spec_wr <= 1'b0;
		#1;
	endtask
	task automatic sp_rd(input logic [3:0] s);
		@(posedge core_clk);
		{spec_rd, spec_sel} <= {1'b1, s};
		@(posedge core_clk);
		spec_rd <= 1'b0;
		#1 v = spec_rdata;
	endtask
	task automatic strobe(input int k, input word_t d);
		@(posedge core_clk);
		{call_en, pc_load, flags_en} <= {k == 0, k == 1, k == 2};
		restricted_op <= (k == 3);
		{call_ret_addr, pc_next, flags_in} <= {d, d, d[4:0]};
		@(posedge core_clk);
		{call_en, pc_load, flags_en, restricted_op} <= 4'h0;
		#1;
	endtask
	task automatic acc(input logic [8:0] n, p, input logic x);
		@(posedge core_clk);
		{exc_req_num, exc_req_prio} <= {n, p};
		@(posedge core_clk);
		#1 cmp_bit(exc_accept, x, "accept");
	endtask
	task automatic exc(input logic r, input logic [8:0] n, input logic ns);
		word_t t;
		@(posedge core_clk);
		{x_req, x_ret, x_num, x_nest} <= {1'b1, r, n, ns};
		t = rnd();
		x_lat <= t[3:0] & 4'h3;
		@(posedge core_clk);
		x_req <= 1'b0;
		for (int k = 0; k < 20; k++)
		begin
			@(posedge core_clk);
			#1;
			if (exc_enter === 1'b1 || exc_return === 1'b1)
				break;
		end
		@(posedge core_clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial
	begin
		#200000;
		n_fail++;
		print_verdict();
	end
	initial
	begin
		{rst_b, rd_narrow, wr_en, wr_narrow, call_en, pc_load} = '0;
		{flags_en, spec_rd, spec_wr, restricted_op, x_req, x_ret} = '0;
		{x_nest, rd_num, wr_num, spec_sel, x_lat, flags_in} = '0;
		{exc_req_num, exc_req_prio, x_num, wr_data, call_ret_addr} = '0;
		{pc_next, spec_wdata, n_fail, n_compared} = '0;
		lfsr_r = 32'h0001_47E2;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		cmp_bit(is_privileged, 1'b1, "priv");
		cmp_bit(in_handler, 1'b0, "handler");
		cmp_bit(using_psp, 1'b0, "psp sel");
		sp_rd(`SPEC_PSW);
		cmp_word(v, 32'h0100_0000, "status");
		for (int s = 4; s < 8; s++)
		begin
			sp_rd(s[3:0]);
			cmp_word(v, 32'h0, "mask reset");
		end
		$display("test reset done");
		for (int n = 0; n < 13; n++)
		begin
			gpr[n] = rnd();
			core_wr(n[3:0], 1'b0, gpr[n]);
			core_rd(n[3:0], 1'b0);
			cmp_word(v, gpr[n], "gpr");
		end
		for (int i = 0; i < 2; i++)
		begin
			w = i ? rnd() : 32'hFFFF_FFFF;
			core_wr(`REG_NUM_SP, 1'b0, w);
			core_rd(`REG_NUM_SP, 1'b0);
			cmp_word(v, w & `SP_ALIGN_MASK, "sp");
			sp_rd(`SPEC_MSP);
			cmp_word(v, w & `SP_ALIGN_MASK, "main sp");
			strobe(1, w);
			cmp_word(pc_out, w & `PC_ALIGN_MASK, "pc");
			strobe(0, w);
			core_rd(`REG_NUM_LR, 1'b0);
			cmp_word(v, w, "link");
		end
		for (int n = 7; n < 13; n++)
		begin
			core_wr(n[3:0], 1'b1, ~gpr[n]);
			cmp_bit(narrow_fault, n > 7, "narrow wr");
			if (n == 7)
				gpr[n] = ~gpr[n];
			core_rd(n[3:0], 1'b1);
			cmp_bit(narrow_fault, n > 7, "narrow rd");
			cmp_word(v, n > 7 ? 32'h0 : gpr[n], "narrow data");
			core_rd(n[3:0], 1'b0);
			cmp_word(v, gpr[n], "wide data");
		end
		$display("test registers done");
		w = rnd();
		strobe(2, w);
		sp_rd(`SPEC_APP);
		cmp_word(v, {w[4:0], 27'h0}, "app");
		e = rnd() | 32'h0100_0000;
		sp_wr(`SPEC_EXE, e);
		cmp_bit(tbit_fault, 1'b0, "tbit ok");
		sp_rd(`SPEC_EXE);
		cmp_word(v, exe_exp(e), "exe");
		sp_wr(`SPEC_EXE, ~e);
		cmp_bit(tbit_fault, 1'b1, "tbit clr");
		sp_rd(`SPEC_EXE);
		cmp_word(v, exe_exp(e), "exe kept");
		sp_rd(`SPEC_PSW);
		cmp_word(v, {w[4:0], 27'h0} | exe_exp(e), "joint");
		exc(1'b0, 9'h010, 1'b0);
		cmp_bit(in_handler, 1'b1, "enter");
		exc(1'b0, 9'h1FF, 1'b0);
		sp_rd(`SPEC_INT);
		cmp_word(v, 32'h0000_01FF, "int nest");
		exc(1'b1, 9'h010, 1'b1);
		sp_rd(`SPEC_INT);
		cmp_word(v, 32'h0000_0010, "int back");
		cmp_bit(in_handler, 1'b1, "still nested");
		exc(1'b1, 9'h000, 1'b0);
		cmp_bit(in_handler, 1'b0, "thread");
		$display("test status done");
		acc(9'h010, 9'h0FF, 1'b1);
		sp_wr(`SPEC_PRIORITY_MASK_BIT, 32'h1);
		acc(`EXC_NMI, 9'h0, 1'b1);
		acc(`EXC_HARDFAULT, 9'h0, 1'b1);
		acc(`EXC_FIRST_IRQ, 9'h0, 1'b0);
		sp_wr(`SPEC_PRIORITY_MASK_BIT, 32'h0);
		sp_wr(`SPEC_FAULT_MASK_BIT, 32'h1);
		acc(`EXC_NMI, 9'h0, 1'b1);
		acc(`EXC_HARDFAULT, 9'h0, 1'b0);
		acc(`EXC_FIRST_IRQ, 9'h0, 1'b0);
		sp_wr(`SPEC_FAULT_MASK_BIT, 32'h0);
		sp_wr(`SPEC_BASE_PRIORITY_THRESHOLD, 32'h20);
		acc(`EXC_FIRST_IRQ, 9'h020, 1'b0);
		acc(`EXC_FIRST_IRQ, 9'h01F, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			w = rnd();
			acc(9'h010 | w[17:9], w[8:0], w[8:0] < 9'h020);
		end
		sp_wr(`SPEC_BASE_PRIORITY_THRESHOLD, 32'h0);
		$display("test masks done");
		strobe(3, 32'h0);
		cmp_bit(priv_fault, 1'b0, "priv op");
		w = rnd();
		sp_wr(`SPEC_PSP, w);
		sp_wr(`SPEC_CONTROL, 32'h2);
		cmp_bit(using_psp, 1'b1, "alt stack");
		core_rd(`REG_NUM_SP, 1'b0);
		cmp_word(v, w & `SP_ALIGN_MASK, "proc sp");
		sp_wr(`SPEC_CONTROL, 32'h3);
		@(posedge core_clk);
		#1;
		cmp_bit(is_privileged, 1'b0, "user");
		strobe(3, 32'h0);
		cmp_bit(priv_fault, 1'b1, "user op");
		sp_wr(`SPEC_PRIORITY_MASK_BIT, 32'h1);
		cmp_bit(priv_fault, 1'b1, "user wr");
		acc(`EXC_FIRST_IRQ, 9'h0, 1'b1);
		exc(1'b0, 9'h011, 1'b0);
		cmp_bit(is_privileged, 1'b1, "handler priv");
		cmp_bit(using_psp, 1'b0, "handler msp");
		sp_wr(`SPEC_CONTROL, 32'h0);
		exc(1'b1, 9'h000, 1'b0);
		cmp_bit(is_privileged, 1'b1, "priv thread");
		cmp_bit(using_psp, 1'b0, "main again");
		$display("test privilege done");
		sp_wr(`SPEC_PRIORITY_MASK_BIT, 32'h1);
		sp_wr(`SPEC_CONTROL, 32'h3);
		@(posedge core_clk);
		rst_b <= 1'b0;
		@(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		cmp_bit(is_privileged, 1'b1, "priv again");
		cmp_bit(using_psp, 1'b0, "main after reset");
		sp_rd(`SPEC_PRIORITY_MASK_BIT);
		cmp_word(v, 32'h0, "mask after reset");
		sp_rd(`SPEC_CONTROL);
		cmp_word(v, 32'h0, "control after reset");
		$display("test reset again done");
		print_verdict();
	end
endmodule // cpu_mode_and_special_regs_tb
